// ---- rtl/mode_lamp_a_console_pkg.sv ----
// shared constants for the maintenance console keypad
package mode_lamp_a_console_pkg;
	localparam int CLK_MHZ        = 20;
	// timing figures in nanoseconds and derived cycle counts
	localparam int PULSE_NS       = 1000;
	localparam int SETTLE_NS      = 500;
	localparam int BOOT_NS        = 2000;
	localparam int READ_TMO_NS    = 10000;
	localparam int PULSE_CYC      = (PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int SETTLE_CYC     = (SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int BOOT_CYC       = (BOOT_NS * CLK_MHZ + 999) / 1000;
	localparam int READ_TMO_CYC   = (READ_TMO_NS * CLK_MHZ) / 1000;
	localparam int CNT_W          = 12;
	// key positions inside the synchronised key vector
	localparam int NKEY           = 10;
	localparam int K_CTRL         = 0;
	localparam int K_ONE          = 1;
	localparam int K_FIVE         = 2;
	localparam int K_SHOWAD       = 3;
	localparam int K_EXAMINE_KEY         = 4;
	localparam int K_HALT         = 5;
	localparam int K_CONTINUE_KEY         = 6;
	localparam int K_BOOT         = 7;
	localparam int K_START        = 8;
	localparam int K_CLEAR        = 9;
	// register byte offsets
	localparam logic [3:0] OFS_CTRL    = 4'h0;
	localparam logic [3:0] OFS_STATUS  = 4'h4;
	localparam logic [3:0] OFS_DISPLAY = 4'h8;
	// control register fields and reset value
	localparam int CTRL_KEY_EN    = 0;
	localparam int CTRL_ERR_CLR   = 1;
	localparam logic CTRL_KEY_EN_RST = 1'b1;
	// status register fields
	localparam int ST_MODE_LAMP_A_BIT   = 0;
	localparam int ST_GATE_BIT    = 1;
	localparam int ST_MASTER_BIT  = 2;
	localparam int ST_BUSERR_BIT  = 3;
	localparam int ST_BUSY_BIT    = 4;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [2:0] {
		ST_CONSOLE = 3'b000,
		ST_MODE_LAMP_A   = 3'b001,
		ST_PULSE   = 3'b010,
		ST_SETTLE  = 3'b011,
		ST_CAPTURE = 3'b100,
		ST_BOOT    = 3'b101,
		ST_BUSRD   = 3'b110
	} mstate_t;

	typedef enum logic [1:0] {
		SRC_ADDR = 2'b00,
		SRC_DATA = 2'b01,
		SRC_MPC  = 2'b10
	} src_t;
endpackage : mode_lamp_a_console_pkg

// ---- rtl/maintenance_console_keypad.sv ----
// maintenance-mode keypad logic with an AXI4-Lite status port
// Overview of operation
// [RULE1] control plus numeral one held together enters maintenance mode
// [RULE2] maintenance lamp lit exactly while in maintenance mode
// [RULE3] in maintenance mode only maintenance keys act; others do nothing
// [RULE4] show-address samples bus address lines once and holds them
// [RULE5] examine samples bus data lines once and displays them
// [RULE6] halt-step asserts manual clock gate then shows micro pc
// [RULE7] continue gives one manual clock pulse then shows new micro pc
// [RULE8] boot fires simulated power fail; display left unchanged
// [RULE9] start releases manual clock gate then shows micro pc
// [RULE10] clear leaves maintenance mode and darkens the lamp
// [RULE11] numeral five returns to console mode and takes the bus
// [RULE12] after takeover read absent pc; failed read lights bus error
// [RULE13] gate assertion stops processor clock, unsynchronised to it
// [RULE14] operator should halt processor before micro-stepping
// [RULE15] sampling and redisplay never pulse the manual clock
// [RULE16] maintenance cable must be fitted except for bus takeover
// [RULE17] run lamp on once gate asserted by halt-step
// [RULE18] power fail only works with bootstrap module installed
// [RULE19] operator loads program counter before entering maintenance mode
// [RULE20] each key acts once per press and release
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module maintenance_console_keypad
	import mode_lamp_a_console_pkg::*;
#(
	parameter int          ADDR_W      = 18,
	parameter int          DATA_W      = 16,
	parameter int          MPC_W       = 9,
	parameter logic [17:0] PC_BUS_ADDR = 18'h0_0000
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              control_key,
	input  wire logic              one_key,
	input  wire logic              five_key,
	input  wire logic              show_address_key,
	input  wire logic              examine_key,
	input  wire logic              halt_step_key,
	input  wire logic              continue_key,
	input  wire logic              boot_key,
	input  wire logic              start_key,
	input  wire logic              clear_key,
	input  wire logic [ADDR_W-1:0] bus_addr_in,
	input  wire logic [DATA_W-1:0] bus_data_in,
	input  wire logic [MPC_W-1:0]  micro_pc,
	input  wire logic              bus_reply_in,
	output logic                   mode_lamp_a,
	output logic                   run_lamp,
	output logic                   bus_err_lamp,
	output logic                   manual_clock_enable,
	output logic                   manual_clock,
	output logic                   power_fail_req,
	output logic                   bus_master,
	output logic                   bus_read_req,
	output logic [ADDR_W-1:0]      bus_read_addr,
	output logic [ADDR_W-1:0]      display,
	input  wire logic [3:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [3:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);
	import mode_lamp_a_console_pkg::*;

	// three-stage synchronisers; a change counts when stages two and three agree
	logic [NKEY-1:0]   key_s1, key_s2, key_s3;
	logic [ADDR_W-1:0] adr_s1, adr_s2, adr_s3;
	logic [DATA_W-1:0] dat_s1, dat_s2, dat_s3;
	logic [MPC_W-1:0]  mpc_s1, mpc_s2, mpc_s3;
	logic [2:0]        rep_s;
	logic [NKEY-1:0]   key_raw;

	assign key_raw = {clear_key, start_key, boot_key, continue_key,
		halt_step_key, examine_key, show_address_key, five_key,
		one_key, control_key};

	always_ff @(posedge aclk) begin
		key_s1 <= key_raw;
		key_s2 <= key_s1;
		key_s3 <= key_s2;
		adr_s1 <= bus_addr_in;
		adr_s2 <= adr_s1;
		adr_s3 <= adr_s2;
		dat_s1 <= bus_data_in;
		dat_s2 <= dat_s1;
		dat_s3 <= dat_s2;
		mpc_s1 <= micro_pc;
		mpc_s2 <= mpc_s1;
		mpc_s3 <= mpc_s2;
		rep_s  <= {rep_s[1:0], bus_reply_in};
	end

	// debounced key levels and press detection
	logic [NKEY-1:0] key_lvl_r, key_lvl_nxt;
	logic            combo_r, combo_nxt;
	logic [NKEY-1:0] press;
	logic            enter_press;

	always_comb begin
		key_lvl_nxt = key_lvl_r;
		for (int i = 0; i < NKEY; i++) begin
			if (key_s2[i] == key_s3[i]) begin
				key_lvl_nxt[i] = key_s3[i];
			end
		end
		combo_nxt = key_lvl_nxt[K_CTRL] & key_lvl_nxt[K_ONE];
	end

	// a held key yields one rising edge only [RULE20]
	assign press       = key_lvl_nxt & ~key_lvl_r;
	assign enter_press = combo_nxt & ~combo_r; // [RULE1]

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			key_lvl_r <= '0;
			combo_r   <= 1'b0;
		end else begin
			key_lvl_r <= key_lvl_nxt;
			combo_r   <= combo_nxt;
		end
	end

	// software control state
	logic key_en_r;
	logic err_clr;

	// main sequencer
	mstate_t           st_r, st_nxt;
	src_t              src_r, src_nxt;
	logic [CNT_W-1:0]  cnt_r, cnt_nxt;
	logic              gate_r, gate_nxt;
	logic              run_r, run_nxt;
	logic              master_r, master_nxt;
	logic              err_r, err_nxt;
	logic [ADDR_W-1:0] disp_r, disp_nxt;
	logic              adr_ok, dat_ok, mpc_ok, reply;

	assign adr_ok = (adr_s2 == adr_s3);
	assign dat_ok = (dat_s2 == dat_s3);
	assign mpc_ok = (mpc_s2 == mpc_s3);
	assign reply  = rep_s[1] & rep_s[2];

	always_comb begin
		st_nxt     = st_r;
		src_nxt    = src_r;
		cnt_nxt    = cnt_r;
		gate_nxt   = gate_r;
		run_nxt    = run_r;
		master_nxt = master_r;
		err_nxt    = err_r;
		disp_nxt   = disp_r;
		if (err_clr) begin
			err_nxt = 1'b0;
		end
		case (st_r)
			ST_CONSOLE: begin
				// console-mode functions live elsewhere; only entry is seen
				if (key_en_r && enter_press) begin
					st_nxt     = ST_MODE_LAMP_A; // [RULE1]
					master_nxt = 1'b0;
				end
			end
			ST_MODE_LAMP_A: begin
				// keys without a maintenance meaning fall through [RULE3]
				if (!key_en_r) begin
					st_nxt = ST_MODE_LAMP_A;
				end else if (press[K_SHOWAD]) begin
					src_nxt = SRC_ADDR; // [RULE4]
					st_nxt  = ST_CAPTURE;
				end else if (press[K_EXAMINE_KEY]) begin
					src_nxt = SRC_DATA; // [RULE5]
					st_nxt  = ST_CAPTURE;
				end else if (press[K_HALT]) begin
					// gate drops straight onto the processor clock [RULE6] [RULE13]
					gate_nxt = 1'b1;
					run_nxt  = 1'b1; // [RULE17]
					src_nxt  = SRC_MPC;
					cnt_nxt  = CNT_W'(SETTLE_CYC);
					st_nxt   = ST_SETTLE; // no clock pulse here [RULE15]
				end else if (press[K_CONTINUE_KEY]) begin
					src_nxt = SRC_MPC;
					cnt_nxt = CNT_W'(PULSE_CYC);
					st_nxt  = ST_PULSE; // [RULE7]
				end else if (press[K_BOOT]) begin
					cnt_nxt = CNT_W'(BOOT_CYC);
					st_nxt  = ST_BOOT; // [RULE8]
				end else if (press[K_START]) begin
					gate_nxt = 1'b0; // [RULE9]
					run_nxt  = 1'b0;
					src_nxt  = SRC_MPC;
					cnt_nxt  = CNT_W'(SETTLE_CYC);
					st_nxt   = ST_SETTLE;
				end else if (press[K_CLEAR]) begin
					gate_nxt = 1'b0; // [RULE10]
					run_nxt  = 1'b0;
					st_nxt   = ST_CONSOLE;
				end else if (press[K_FIVE]) begin
					gate_nxt   = 1'b0;
					run_nxt    = 1'b0;
					master_nxt = 1'b1; // [RULE11]
					cnt_nxt    = CNT_W'(READ_TMO_CYC);
					st_nxt     = ST_BUSRD; // [RULE12]
				end
			end
			ST_PULSE: begin
				// a single pulse per press [RULE7]
				if (cnt_r == '0) begin
					cnt_nxt = CNT_W'(SETTLE_CYC);
					st_nxt  = ST_SETTLE;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			ST_SETTLE: begin
				if (cnt_r == '0) begin
					st_nxt = ST_CAPTURE;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			ST_CAPTURE: begin
				// take the word only once, when it is steady in the synchroniser
				case (src_r)
					SRC_ADDR: begin
						if (adr_ok) begin
							disp_nxt = adr_s3; // [RULE4]
							st_nxt   = ST_MODE_LAMP_A;
						end
					end
					SRC_DATA: begin
						if (dat_ok) begin
							disp_nxt = ADDR_W'(dat_s3); // [RULE5]
							st_nxt   = ST_MODE_LAMP_A;
						end
					end
					default: begin
						if (mpc_ok) begin
							disp_nxt = ADDR_W'(mpc_s3); // [RULE6] [RULE9]
							st_nxt   = ST_MODE_LAMP_A;
						end
					end
				endcase
			end
			ST_BOOT: begin
				// display untouched while the power fail request runs [RULE8]
				if (cnt_r == '0) begin
					st_nxt = ST_MODE_LAMP_A;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			ST_BUSRD: begin
				if (reply) begin
					disp_nxt = ADDR_W'(dat_s3);
					st_nxt   = ST_CONSOLE;
				end else if (cnt_r == '0) begin
					err_nxt = 1'b1; // set wins over software clear [RULE12]
					st_nxt  = ST_CONSOLE;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			default: begin
				st_nxt = ST_CONSOLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r     <= ST_CONSOLE;
			src_r    <= SRC_MPC;
			cnt_r    <= '0;
			gate_r   <= 1'b0;
			run_r    <= 1'b0;
			master_r <= 1'b0;
			err_r    <= 1'b0;
			disp_r   <= '0;
		end else begin
			st_r     <= st_nxt;
			src_r    <= src_nxt;
			cnt_r    <= cnt_nxt;
			gate_r   <= gate_nxt;
			run_r    <= run_nxt;
			master_r <= master_nxt;
			err_r    <= err_nxt;
			disp_r   <= disp_nxt;
		end
	end

	logic in_mode_lamp_a;
	assign in_mode_lamp_a = (st_r != ST_CONSOLE) && (st_r != ST_BUSRD);

	assign mode_lamp_a         = in_mode_lamp_a; // [RULE2] [RULE10] [RULE11]
	assign run_lamp            = run_r; // [RULE17]
	assign bus_err_lamp        = err_r;
	assign manual_clock_enable = gate_r; // [RULE13]
	assign manual_clock        = (st_r == ST_PULSE); // [RULE7] [RULE15]
	assign power_fail_req      = (st_r == ST_BOOT); // [RULE8]
	assign bus_master          = master_r;
	assign bus_read_req        = (st_r == ST_BUSRD);
	assign bus_read_addr       = ADDR_W'(PC_BUS_ADDR);
	assign display             = disp_r;

	// AXI4-Lite slave: address and data taken in either order
	logic        aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
	logic [3:0]  aw_adr_r, aw_adr_nxt;
	logic [31:0] w_dat_r, w_dat_nxt;
	logic        w_lane_r, w_lane_nxt;
	logic        bvalid_r, bvalid_nxt;
	logic [1:0]  bresp_r, bresp_nxt;
	logic        rvalid_r, rvalid_nxt;
	logic [1:0]  rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic        key_en_nxt;

	assign s_axi_awready = ~aw_got_r & ~bvalid_r;
	assign s_axi_wready  = ~w_got_r & ~bvalid_r;
	assign s_axi_arready = ~rvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rresp   = rresp_r;
	assign s_axi_rdata   = rdata_r;

	always_comb begin
		aw_got_nxt = aw_got_r;
		w_got_nxt  = w_got_r;
		aw_adr_nxt = aw_adr_r;
		w_dat_nxt  = w_dat_r;
		w_lane_nxt = w_lane_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt  = bresp_r;
		rvalid_nxt = rvalid_r;
		rresp_nxt  = rresp_r;
		rdata_nxt  = rdata_r;
		key_en_nxt = key_en_r;
		err_clr    = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_got_nxt = 1'b1;
			aw_adr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_got_nxt  = 1'b1;
			w_dat_nxt  = s_axi_wdata;
			w_lane_nxt = s_axi_wstrb[0];
		end
		if (aw_got_r && w_got_r) begin
			aw_got_nxt = 1'b0;
			w_got_nxt  = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt  = RESP_OKAY;
			if (aw_adr_r == OFS_CTRL) begin
				if (w_lane_r) begin
					key_en_nxt = w_dat_r[CTRL_KEY_EN];
					err_clr    = w_dat_r[CTRL_ERR_CLR];
				end
			end else if (aw_adr_r == OFS_STATUS || aw_adr_r == OFS_DISPLAY) begin
				bresp_nxt = RESP_OKAY;
			end else begin
				bresp_nxt = RESP_SLVERR;
			end
		end
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = RESP_OKAY;
			rdata_nxt  = '0;
			if (s_axi_araddr == OFS_CTRL) begin
				rdata_nxt[CTRL_KEY_EN] = key_en_r;
			end else if (s_axi_araddr == OFS_STATUS) begin
				rdata_nxt[ST_MODE_LAMP_A_BIT]  = in_mode_lamp_a;
				rdata_nxt[ST_GATE_BIT]   = gate_r;
				rdata_nxt[ST_MASTER_BIT] = master_r;
				rdata_nxt[ST_BUSERR_BIT] = err_r;
				rdata_nxt[ST_BUSY_BIT]   = (st_r != ST_CONSOLE) &&
					(st_r != ST_MODE_LAMP_A);
			end else if (s_axi_araddr == OFS_DISPLAY) begin
				rdata_nxt[ADDR_W-1:0] = disp_r;
			end else begin
				rresp_nxt = RESP_SLVERR;
			end
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r  <= 1'b0;
			aw_adr_r <= '0;
			w_dat_r  <= '0;
			w_lane_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r  <= RESP_OKAY;
			rdata_r  <= '0;
			key_en_r <= CTRL_KEY_EN_RST;
		end else begin
			aw_got_r <= aw_got_nxt;
			w_got_r  <= w_got_nxt;
			aw_adr_r <= aw_adr_nxt;
			w_dat_r  <= w_dat_nxt;
			w_lane_r <= w_lane_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r  <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r  <= rresp_nxt;
			rdata_r  <= rdata_nxt;
			key_en_r <= key_en_nxt;
		end
	end
endmodule : maintenance_console_keypad

// ---- verification/mode_lamp_a_console_props.sv ----
// assertions on the maintenance console keypad outputs
`timescale 1ns/1ns
module mode_lamp_a_console_props
	import mode_lamp_a_console_pkg::*;
(
	input wire logic		aclk,
	input wire logic		aresetn,
	input wire logic		mode_lamp_a,
	input wire logic		run_lamp,
	input wire logic		bus_err_lamp,
	input wire logic		manual_clock_enable,
	input wire logic		manual_clock,
	input wire logic		power_fail_req,
	input wire logic		bus_master,
	input wire logic		bus_read_req,
	input wire logic [17:0]	display
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// run lengths of the two timed pulses, cleared while they are low
	logic [7:0]	mc_cnt_r, mc_cnt_nxt, pf_cnt_r, pf_cnt_nxt;
	always_comb begin
		mc_cnt_nxt = manual_clock ? mc_cnt_r + 8'h01 : 8'h00;
		pf_cnt_nxt = power_fail_req ? pf_cnt_r + 8'h01 : 8'h00;
	end
	always_ff @(posedge aclk) begin
		mc_cnt_r <= aresetn ? mc_cnt_nxt : 8'h00;
		pf_cnt_r <= aresetn ? pf_cnt_nxt : 8'h00;
	end
	pulse_width_a: assert property (
		$fell(manual_clock) |-> mc_cnt_r == 8'(PULSE_CYC + 1))
		else $error("manual clock pulse has the wrong width");
	fail_width_a: assert property (
		$fell(power_fail_req) |-> pf_cnt_r == 8'(BOOT_CYC + 1))
		else $error("power fail request has the wrong width");
	boot_display_a: assert property (
		power_fail_req |-> $stable(display))
		else $error("display moved during power fail");
	run_on_a: assert property (
		$rose(manual_clock_enable) |-> ##[0:1] run_lamp)
		else $error("run lamp not lit after gate asserted");
	gate_mode_lamp_a_a: assert property (
		$rose(manual_clock_enable) |-> mode_lamp_a)
		else $error("gate asserted outside maintenance mode");
	exit_gate_a: assert property (
		$fell(mode_lamp_a) |-> ##[0:1] !manual_clock_enable)
		else $error("gate still held after leaving maintenance");
	master_mode_a: assert property (
		$rose(bus_master) |-> !mode_lamp_a)
		else $error("bus taken while still in maintenance mode");
	err_cause_a: assert property (
		$rose(bus_err_lamp) |->
		bus_master && ($past(bus_read_req) || $past(bus_read_req, 2)))
		else $error("bus error lamp without a failed read");
	read_bound_a: assert property (
		$rose(bus_read_req) |-> ##[1:210] !bus_read_req)
		else $error("program counter read never ended");
	still_display_a: assert property (
		$changed(display) |-> !manual_clock)
		else $error("display sampled while clock pulse high");
	cover property ($rose(manual_clock));
	cover property ($rose(power_fail_req));
	cover property ($rose(bus_err_lamp));
endmodule : mode_lamp_a_console_props

bind maintenance_console_keypad mode_lamp_a_console_props u_props (
	.aclk, .aresetn, .mode_lamp_a, .run_lamp, .bus_err_lamp,
	.manual_clock_enable, .manual_clock, .power_fail_req, .bus_master,
	.bus_read_req, .display
);

// ---- verification/cpu_side_model.sv ----
// behavioural processor microsequencer and bus slave
`timescale 1ns/1ns
module cpu_side_model #(
	parameter logic [8:0]	START_MPC = 9'h040,
	parameter logic [8:0]	POWERUP_MPC = 9'h018,
	parameter int		REPLY_DLY = 6
) (
	input wire logic		aclk,
	input wire logic		aresetn,
	input wire logic		cpu_run,
	input wire logic		cpu_fitted,
	input wire logic		boot_fitted,
	input wire logic		manual_clock_enable,
	input wire logic		manual_clock,
	input wire logic		power_fail_req,
	input wire logic		bus_read_req,
	output logic [8:0]		micro_pc,
	output logic		bus_reply_in
);
	logic	mc_q, pf_q;
	int	wait_cnt;
	always @(posedge aclk) begin
		mc_q <= manual_clock;
		pf_q <= power_fail_req;
		if (!aresetn) begin
			micro_pc <= START_MPC;
			wait_cnt <= 0;
			bus_reply_in <= 1'h0;
		end else begin
			// the gate freezes a running clock, whatever its phase
			if (!manual_clock_enable && cpu_run)
				micro_pc <= micro_pc + 9'h001;
			if (manual_clock_enable && manual_clock && !mc_q)
				micro_pc <= micro_pc + 9'h001;
			// power fail only with the bootstrap fitted
			if (manual_clock_enable && power_fail_req && !pf_q && boot_fitted)
				micro_pc <= POWERUP_MPC;
			// an absent processor never answers its pc read
			if (bus_read_req && cpu_fitted)
				wait_cnt <= wait_cnt + 1;
			else
				wait_cnt <= 0;
			bus_reply_in <= bus_read_req && cpu_fitted && wait_cnt >= REPLY_DLY;
		end
	end
endmodule : cpu_side_model

// ---- verification/maintenance_console_keypad_test.sv ----
// self-checking bench for the maintenance console keypad
`timescale 1ns/1ns
module maintenance_console_keypad_test;
	import mode_lamp_a_console_pkg::*;
	localparam logic [8:0]	M0 = 9'h040;
	localparam logic [8:0]	PW = 9'h018;
	localparam logic [17:0]	AD = 18'h2_5a3c;
	localparam logic [15:0]	DT = 16'hc3a5;
	localparam logic [17:0]	EM = {9'h000, M0};
	localparam logic [17:0]	EP = {9'h000, PW};
	localparam logic [17:0]	ON = 18'h0_0001;
	typedef struct {
		int		k;
		int		hold;
		logic [17:0]	disp;
		logic		gate;
	} row_t;
	logic		aclk = 1'h0;
	logic		aresetn = 1'h0;
	logic [9:0]	keys = '0;
	logic [17:0]	bus_addr_in = AD;
	logic [15:0]	bus_data_in = DT; // preloaded pc
	logic		cpu_fitted = 1'h0;
	logic [8:0]	micro_pc;
	logic		bus_reply_in, mode_lamp_a, run_lamp, bus_err_lamp;
	logic		manual_clock_enable, manual_clock, power_fail_req;
	logic		bus_master, bus_read_req;
	logic [17:0]	display;
	logic [17:0]	read_addr;
	logic [3:0]	awaddr = '0;
	logic [3:0]	araddr = '0;
	logic [31:0]	wdata = '0;
	// response readies stay high: back-to-back calls never retoggle them
	logic		awvalid = 1'h0, wvalid = 1'h0, bready = 1'h1;
	logic		arvalid = 1'h0, rready = 1'h1;
	logic		awready, wready, bvalid, arready, rvalid;
	logic [31:0]	rdata, rd_word;
	logic [1:0]	bresp, rresp, resp;
	int		errors = 0;
	int		check_count = 0;
	row_t rows [10] = '{
		'{K_SHOWAD, 8, AD, 1'h0},
		'{K_EXAMINE_KEY, 8, {2'h0, DT}, 1'h0},
		'{K_HALT, 8, EM, 1'h1},
		'{K_CONTINUE_KEY, 8, EM + ON, 1'h1},
		'{K_CONTINUE_KEY, 60, EM + 18'h0_0002, 1'h1},
		'{K_HALT, 8, EM + 18'h0_0002, 1'h1},
		'{K_BOOT, 8, EM + 18'h0_0002, 1'h1},
		'{K_HALT, 8, EP, 1'h1},
		'{K_CONTINUE_KEY, 8, EP + ON, 1'h1},
		'{K_START, 8, EP + ON, 1'h0}
	};

	always #25 aclk = ~aclk;

	maintenance_console_keypad u_dut (
		.aclk, .aresetn,
		.control_key(keys[K_CTRL]), .one_key(keys[K_ONE]),
		.five_key(keys[K_FIVE]), .show_address_key(keys[K_SHOWAD]),
		.examine_key(keys[K_EXAMINE_KEY]), .halt_step_key(keys[K_HALT]),
		.continue_key(keys[K_CONTINUE_KEY]), .boot_key(keys[K_BOOT]),
		.start_key(keys[K_START]), .clear_key(keys[K_CLEAR]),
		.bus_addr_in, .bus_data_in, .micro_pc, .bus_reply_in,
		.mode_lamp_a, .run_lamp, .bus_err_lamp, .manual_clock_enable,
		.manual_clock, .power_fail_req, .bus_master, .bus_read_req,
		.bus_read_addr(read_addr), .display,
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
	);

	cpu_side_model #(.START_MPC(M0), .POWERUP_MPC(PW), .REPLY_DLY(6)) u_cpu (
		.aclk, .aresetn,
		.cpu_run(1'h0), // processor halted before maintenance
		.cpu_fitted, .boot_fitted(1'h1), // bootstrap module fitted
		.manual_clock_enable, .manual_clock, .power_fail_req, .bus_read_req,
		.micro_pc, .bus_reply_in
	);

	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'h0;
			if (wvalid && wready) wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		resp = bresp;
	endtask : wr

	task automatic rd(input logic [3:0] a);
		araddr <= a;
		arvalid <= 1'h1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		rd_word = rdata;
		resp = rresp;
	endtask : rd

	// polling busy avoids guessing each action's length
	task automatic press(input int k, input int hold);
		keys[k] <= 1'h1;
		repeat (hold) @(posedge aclk);
		keys[k] <= 1'h0;
		do begin
			rd(OFS_STATUS);
		end while (rd_word[ST_BUSY_BIT] !== 1'h0);
	endtask : press

	task automatic enter();
		keys[K_CTRL] <= 1'h1;
		keys[K_ONE] <= 1'h1;
		repeat (8) @(posedge aclk);
		keys <= '0;
		repeat (8) @(posedge aclk);
	endtask : enter

	task automatic close_out();
		$display("errors=%0d checks=%0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : close_out

	initial begin
		repeat (20000) @(posedge aclk);
		errors++;
		close_out();
	end

	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		rd(OFS_CTRL);
		chk(rd_word[17:0], ON);
		rd(OFS_STATUS);
		chk(rd_word[17:0], 18'h0_0000);
		rd(4'hc);
		chk(18'(resp), 18'(RESP_SLVERR));
		wr(4'hc, 32'hffff_ffff);
		chk(18'(resp), 18'(RESP_SLVERR));
		press(K_HALT, 8);
		chk(18'(manual_clock_enable), 18'h0_0000);
		enter();
		rd(OFS_STATUS);
		chk(rd_word[17:0], ON);
		foreach (rows[i]) begin
			press(rows[i].k, rows[i].hold);
			chk(display, rows[i].disp);
			chk(18'(manual_clock_enable), 18'(rows[i].gate));
			chk(18'(run_lamp), 18'(rows[i].gate));
		end
		press(K_SHOWAD, 8);
		bus_addr_in <= ~AD;
		repeat (20) @(posedge aclk);
		chk(display, AD);
		press(K_HALT, 8);
		chk(display, EP + ON);
		// keys disabled from software: clear must be ignored
		wr(OFS_CTRL, 32'h0000_0000);
		press(K_CLEAR, 8);
		chk(18'(mode_lamp_a), 18'h0_0001);
		wr(OFS_CTRL, 32'h0000_0001);
		press(K_CLEAR, 8);
		chk(18'(mode_lamp_a), 18'h0_0000);
		chk(18'(manual_clock_enable), 18'h0_0000);
		press(K_CONTINUE_KEY, 8);
		chk(display, EP + ON);
		enter();
		press(K_FIVE, 8);
		rd(OFS_STATUS);
		chk(rd_word[17:0], 18'h0_000c);
		chk(18'(bus_err_lamp), 18'h0_0001);
		chk(18'(bus_master), 18'h0_0001);
		chk(read_addr, 18'h0_0000);
		wr(OFS_CTRL, 32'h0000_0003);
		rd(OFS_STATUS);
		chk(rd_word[17:0], 18'h0_0004);
		cpu_fitted <= 1'h1;
		enter();
		press(K_FIVE, 8);
		rd(OFS_STATUS);
		chk(rd_word[17:0], 18'h0_0004);
		chk(display, {2'h0, DT});
		// reset in mid-run drops bus ownership and the display
		aresetn <= 1'h0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		chk(display, 18'h0_0000);
		chk(18'(bus_master), 18'h0_0000);
		rd(OFS_CTRL);
		chk(rd_word[17:0], ON);
		close_out();
	end
endmodule : maintenance_console_keypad_test
